//--- src/irq_flag_bank_map.vh
// register map, field positions and reset values of the interrupt flag bank
`ifndef IRQ_FLAG_BANK_MAP_VH
`define IRQ_FLAG_BANK_MAP_VH

// register byte offsets, one aligned 32-bit word each
`define OFS_FLAGS_GROUP0 8'h00
`define OFS_FLAGS_GROUP1 8'h04
`define OFS_FLAGS_GROUP2 8'h08
`define OFS_EVENT_STATUS 8'h0C
`define OFS_EVENT_MASK 8'h10

// reset values
`define FLAGS_RESET 16'h0000
`define EVSTAT_RESET 3'h0
`define EVMASK_RESET 3'h0
`define RDATA_RESET 32'h00000000

// implemented bit masks, unimplemented positions read zero
`define IMPL_GROUP0 16'h0007
`define IMPL_GROUP1 16'hFFFB
`define IMPL_GROUP2 16'hDFFF

// group 0 positions
`define G0_COMPARE1 2
`define G0_CAPTURE1 1
`define G0_EXT_PIN0 0

// group 1 positions
`define G1_UART_B_TX 15
`define G1_UART_B_RX 14
`define G1_EXT_PIN2 13
`define G1_TIMER_E 12
`define G1_TIMER_D 11
`define G1_COMPARE4 10
`define G1_COMPARE3 9
`define G1_XFER_CH2 8
`define G1_CAPTURE8 7
`define G1_CAPTURE7 6
`define G1_ADC_B 5
`define G1_EXT_PIN1 4
`define G1_PIN_CHANGE 3
`define G1_I2C_A_MASTER 1
`define G1_I2C_A_SLAVE 0

// group 2 positions
`define G2_TIMER_F 15
`define G2_XFER_CH4 14
`define G2_COMPARE8 12
`define G2_COMPARE7 11
`define G2_COMPARE6 10
`define G2_COMPARE5 9
`define G2_CAPTURE6 8
`define G2_CAPTURE5 7
`define G2_CAPTURE4 6
`define G2_CAPTURE3 5
`define G2_XFER_CH3 4
`define G2_CAN_A_EVENT 3
`define G2_CAN_A_RX 2
`define G2_SPI_B_EVENT 1
`define G2_SPI_B_ERROR 0

// event status / mask layout: one bit per flag group
`define EV_GROUP0 0
`define EV_GROUP1 1
`define EV_GROUP2 2

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- src/flag_reg16.v
// one 16-bit sticky flag register with software read/write access
`timescale 1ns/10ps
module flag_reg16 #(
	parameter [15:0] IMPL_MASK = 16'hFFFF // implemented positions
) (
	input wire aclk,
	input wire aresetn,
	input wire ce, // freezes the register while low
	input wire [15:0] evt, // peripheral requests, level sampled each edge
	input wire wr_en, // software write this cycle
	input wire [15:0] wr_data,
	input wire [1:0] wr_strb, // byte lanes of the write
	output reg [15:0] flags_q, // current flags
	output wire raised // some flag goes from clear to set by hardware
);
`include "irq_flag_bank_map.vh"

	wire [15:0] lane_mask; // bits covered by the write strobes
	reg [15:0] flags_d;

	assign lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
	assign raised = |(evt & ~flags_q & IMPL_MASK);

	// next flag value: software write first, then events or'ed on top
	always @* begin
		flags_d = flags_q;
		if (wr_en) begin
			flags_d = (flags_q & ~lane_mask) | (wr_data & lane_mask); // [R8]
		end
		// an event in the clearing cycle still sets the flag [R9] [R7]
		flags_d = (flags_d | evt) & IMPL_MASK; // [R4] [R8]
	end

	// flags hold until software writes them to zero
	always @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= `FLAGS_RESET; // [R8]
		end else if (ce) begin
			flags_q <= flags_d; // [R9]
		end
	end
endmodule

//--- src/irq_flag_bank.v
// interrupt flag status bank: three flag groups behind an axi4-lite slave
//
// Function
// R1: group0 bit2 compare1, bit1 capture1, bit0 pin0
// R2: group1 high byte: uart, pin2, timers, compares, dma
// R3: group1 low byte: captures, adc, pin1, change, i2c
// R4: group1 bit 2 always reads zero
// R5: group2 high byte mapping; bit 13 reads zero
// R6: group2 low byte: captures, dma3, can, spi
// R7: flag reads one once its request occurred
// R8: flags read/write, reset zero; unimplemented ignore writes
// R9: flag sticky until written zero; event wins
`timescale 1ns/10ps
module irq_flag_bank (
	input wire aclk,
	input wire aresetn, // synchronous, active low
	input wire ce, // clock enable, freezes all state when low
	// axi4-lite write address channel
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data channel
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response channel
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address channel
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data channel
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// group 0 request sources
	input wire compare1_req,
	input wire capture1_req,
	input wire ext_pin0_req,
	// group 1 request sources
	input wire uart_b_tx_req,
	input wire uart_b_rx_req,
	input wire ext_pin2_req,
	input wire timer_e_req,
	input wire timer_d_req,
	input wire compare4_req,
	input wire compare3_req,
	input wire xfer_ch2_done,
	input wire capture8_req,
	input wire capture7_req,
	input wire adc_b_done,
	input wire ext_pin1_req,
	input wire pin_change_req,
	input wire i2c_a_master_req,
	input wire i2c_a_slave_req,
	// group 2 request sources
	input wire timer_f_req,
	input wire xfer_ch4_done,
	input wire compare8_req,
	input wire compare7_req,
	input wire compare6_req,
	input wire compare5_req,
	input wire capture6_req,
	input wire capture5_req,
	input wire capture4_req,
	input wire capture3_req,
	input wire xfer_ch3_done,
	input wire can_a_event,
	input wire can_a_rx_ready,
	input wire spi_b_event,
	input wire spi_b_error,
	// flag views for the cpu-side interrupt logic
	output wire [15:0] irq_flags_group0,
	output wire [15:0] irq_flags_group1,
	output wire [15:0] irq_flags_group2,
	// one level interrupt, high while an unmasked event bit is set
	output wire irq
);
`include "irq_flag_bank_map.vh"

////////////////////////////////////////////////////////////////////////////////
// event vectors

	reg [15:0] evt0; // group 0 requests at their positions
	reg [15:0] evt1; // group 1 requests
	reg [15:0] evt2; // group 2 requests

	// place group 0 sources, other bits stay zero
	always @* begin
		evt0 = `FLAGS_RESET;
		evt0[`G0_COMPARE1] = compare1_req; // [R1]
		evt0[`G0_CAPTURE1] = capture1_req; // [R1]
		evt0[`G0_EXT_PIN0] = ext_pin0_req; // [R1]
	end

	// place group 1 sources; position 2 has no source
	always @* begin
		evt1 = `FLAGS_RESET;
		evt1[`G1_UART_B_TX] = uart_b_tx_req; // [R2]
		evt1[`G1_UART_B_RX] = uart_b_rx_req; // [R2]
		evt1[`G1_EXT_PIN2] = ext_pin2_req; // [R2]
		evt1[`G1_TIMER_E] = timer_e_req; // [R2]
		evt1[`G1_TIMER_D] = timer_d_req; // [R2]
		evt1[`G1_COMPARE4] = compare4_req; // [R2]
		evt1[`G1_COMPARE3] = compare3_req; // [R2]
		evt1[`G1_XFER_CH2] = xfer_ch2_done; // [R2]
		evt1[`G1_CAPTURE8] = capture8_req; // [R3]
		evt1[`G1_CAPTURE7] = capture7_req; // [R3]
		evt1[`G1_ADC_B] = adc_b_done; // [R3]
		evt1[`G1_EXT_PIN1] = ext_pin1_req; // [R3]
		evt1[`G1_PIN_CHANGE] = pin_change_req; // [R3]
		evt1[`G1_I2C_A_MASTER] = i2c_a_master_req; // [R3]
		evt1[`G1_I2C_A_SLAVE] = i2c_a_slave_req; // [R3]
	end

	// place group 2 sources; position 13 has no source
	always @* begin
		evt2 = `FLAGS_RESET;
		evt2[`G2_TIMER_F] = timer_f_req; // [R5]
		evt2[`G2_XFER_CH4] = xfer_ch4_done; // [R5]
		evt2[`G2_COMPARE8] = compare8_req; // [R5]
		evt2[`G2_COMPARE7] = compare7_req; // [R5]
		evt2[`G2_COMPARE6] = compare6_req; // [R5]
		evt2[`G2_COMPARE5] = compare5_req; // [R5]
		evt2[`G2_CAPTURE6] = capture6_req; // [R5]
		evt2[`G2_CAPTURE5] = capture5_req; // [R6]
		evt2[`G2_CAPTURE4] = capture4_req; // [R6]
		evt2[`G2_CAPTURE3] = capture3_req; // [R6]
		evt2[`G2_XFER_CH3] = xfer_ch3_done; // [R6]
		evt2[`G2_CAN_A_EVENT] = can_a_event; // [R6]
		evt2[`G2_CAN_A_RX] = can_a_rx_ready; // [R6]
		evt2[`G2_SPI_B_EVENT] = spi_b_event; // [R6]
		evt2[`G2_SPI_B_ERROR] = spi_b_error; // [R6]
	end

////////////////////////////////////////////////////////////////////////////////
// axi write path

	reg aw_full_q; // write address held, waiting for data
	reg [7:0] aw_addr_q; // held write address
	reg w_full_q; // write data held, waiting for address
	reg [31:0] w_data_q; // held write data
	reg [3:0] w_strb_q; // held write strobes
	wire aw_fire; // address taken this edge
	wire w_fire; // data taken this edge
	wire wr_go; // both halves present, perform the write
	wire wr_mapped; // held address hits a register

	// no new halves while a response is pending: one write at a time
	assign s_axi_awready = ce & ~aw_full_q & ~s_axi_bvalid;
	assign s_axi_wready = ce & ~w_full_q & ~s_axi_bvalid;
	assign aw_fire = s_axi_awvalid & s_axi_awready;
	assign w_fire = s_axi_wvalid & s_axi_wready;
	assign wr_go = ce & aw_full_q & w_full_q;
	assign wr_mapped = (aw_addr_q == `OFS_FLAGS_GROUP0) |
		(aw_addr_q == `OFS_FLAGS_GROUP1) |
		(aw_addr_q == `OFS_FLAGS_GROUP2) |
		(aw_addr_q == `OFS_EVENT_STATUS) |
		(aw_addr_q == `OFS_EVENT_MASK);

	// capture address and data in either order, then respond
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= `OFS_FLAGS_GROUP0;
			w_full_q <= 1'b0;
			w_data_q <= `RDATA_RESET;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (ce) begin
			if (aw_fire) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[7:2], 2'b00}; // low bits ignored
			end
			if (w_fire) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				// the register update happens in this same edge
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// per-register write enables
	wire wr_grp0 = wr_go & (aw_addr_q == `OFS_FLAGS_GROUP0);
	wire wr_grp1 = wr_go & (aw_addr_q == `OFS_FLAGS_GROUP1);
	wire wr_grp2 = wr_go & (aw_addr_q == `OFS_FLAGS_GROUP2);
	wire wr_mask = wr_go & (aw_addr_q == `OFS_EVENT_MASK);

////////////////////////////////////////////////////////////////////////////////
// flag groups

	wire [15:0] flags0; // group 0 flags
	wire [15:0] flags1; // group 1 flags
	wire [15:0] flags2; // group 2 flags
	wire raised0; // a group 0 flag newly set by hardware
	wire raised1;
	wire raised2;

	// group 0: only the low three positions exist in this block
	flag_reg16 #(
		.IMPL_MASK(`IMPL_GROUP0)
	) u_group0 (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.evt(evt0),
		.wr_en(wr_grp0),
		.wr_data(w_data_q[15:0]),
		.wr_strb(w_strb_q[1:0]),
		.flags_q(flags0),
		.raised(raised0)
	);

	// group 1: position 2 unimplemented [R4]
	flag_reg16 #(
		.IMPL_MASK(`IMPL_GROUP1)
	) u_group1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.evt(evt1),
		.wr_en(wr_grp1),
		.wr_data(w_data_q[15:0]),
		.wr_strb(w_strb_q[1:0]),
		.flags_q(flags1),
		.raised(raised1)
	);

	// group 2: position 13 unimplemented [R5]
	flag_reg16 #(
		.IMPL_MASK(`IMPL_GROUP2)
	) u_group2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.evt(evt2),
		.wr_en(wr_grp2),
		.wr_data(w_data_q[15:0]),
		.wr_strb(w_strb_q[1:0]),
		.flags_q(flags2),
		.raised(raised2)
	);

	// cpu-side interrupt logic samples the flags directly
	assign irq_flags_group0 = flags0;
	assign irq_flags_group1 = flags1;
	assign irq_flags_group2 = flags2;

////////////////////////////////////////////////////////////////////////////////
// axi read path

	wire ar_fire; // read address taken this edge
	wire [7:0] rd_addr; // word-aligned read address
	reg [31:0] rd_mux; // data selected for the read
	reg rd_hit; // read address is mapped

	// one read at a time: no new address until rdata is taken
	assign s_axi_arready = ce & ~s_axi_rvalid;
	assign ar_fire = s_axi_arvalid & s_axi_arready;
	assign rd_addr = {s_axi_araddr[7:2], 2'b00};

	// event status and mask registers declared ahead of the mux
	reg [2:0] ev_status_q; // sticky group events, cleared by read
	reg [2:0] ev_mask_q; // one enables the event onto irq
	wire [2:0] ev_raise; // events of this cycle

	// read data select; upper bits of every word read zero
	always @* begin
		rd_mux = `RDATA_RESET;
		rd_hit = 1'b1;
		case (rd_addr)
			`OFS_FLAGS_GROUP0: begin
				rd_mux[15:0] = flags0; // [R7]
			end
			`OFS_FLAGS_GROUP1: begin
				rd_mux[15:0] = flags1; // [R7]
			end
			`OFS_FLAGS_GROUP2: begin
				rd_mux[15:0] = flags2; // [R7]
			end
			`OFS_EVENT_STATUS: begin
				rd_mux[2:0] = ev_status_q;
			end
			`OFS_EVENT_MASK: begin
				rd_mux[2:0] = ev_mask_q;
			end
			default: begin
				rd_hit = 1'b0; // unmapped: zero data, error response
			end
		endcase
	end

	// read data comes from flip-flops, one cycle after the address
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `RDATA_RESET;
			s_axi_rresp <= `RESP_OKAY;
		end else if (ce) begin
			if (ar_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// event status, mask and interrupt

	wire rd_status; // status register read taken this edge

	assign rd_status = ar_fire & (rd_addr == `OFS_EVENT_STATUS);
	assign ev_raise[`EV_GROUP0] = raised0;
	assign ev_raise[`EV_GROUP1] = raised1;
	assign ev_raise[`EV_GROUP2] = raised2;

	// read clears the status; an event in the same cycle still sets it
	always @(posedge aclk) begin
		if (!aresetn) begin
			ev_status_q <= `EVSTAT_RESET;
			ev_mask_q <= `EVMASK_RESET;
		end else if (ce) begin
			if (rd_status) begin
				ev_status_q <= ev_raise; // set beats the read clear
			end else begin
				ev_status_q <= ev_status_q | ev_raise;
			end
			if (wr_mask & w_strb_q[0]) begin
				ev_mask_q <= w_data_q[2:0];
			end
		end
	end

	// level interrupt while any unmasked status bit is set
	assign irq = |(ev_status_q & ev_mask_q);

	// protection bits are accepted but play no part in this block
	wire unused_prot = ^{s_axi_awprot, s_axi_arprot, w_strb_q[3:2], w_data_q[31:16]};
endmodule

//--- sim/req_sources.sv
// peripheral request sources driving the flag bank's request inputs
`timescale 1ns/10ps
module req_sources (
	input wire aclk,
	input wire aresetn,
	input wire [47:0] cmd, // one bit per flag position, bench commanded
	output reg [47:0] req // registered request levels
);
	// sources are logic, so a released request goes low, never floats
	always @(posedge aclk) begin
		req <= aresetn ? cmd : 48'h0;
	end
endmodule

//--- sim/irq_flag_bank_asserts.sv
// concurrent checks on the ports of the interrupt flag bank
`timescale 1ns/10ps
module irq_flag_bank_asserts (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire ext_pin0_req,
	input wire timer_e_req,
	input wire pin_change_req,
	input wire spi_b_error,
	input wire [15:0] irq_flags_group0,
	input wire [15:0] irq_flags_group1,
	input wire [15:0] irq_flags_group2,
	input wire irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire [47:0] all = {irq_flags_group2, irq_flags_group1, irq_flags_group0}; // all flags
	//////////////////////////////
	// bus steps
	sequence both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_waiting;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	// reset must win even over a pending request, hence no disable
	property reset_clears;
		disable iff (1'b0) !aresetn |=> !irq && !s_axi_bvalid && !s_axi_rvalid && all == 48'h0;
	endproperty
	//////////////////////////////
	a_reset_clear: assert property (reset_clears)
		else $error("state not cleared by reset");
	a_unimpl_zero: assert property (irq_flags_group0[15:3] == 13'h0
		&& !irq_flags_group1[2] && !irq_flags_group2[13])
		else $error("unimplemented flag set");
	a_pin0_sets: assert property (ce && ext_pin0_req |=> irq_flags_group0[0])
		else $error("pin0 flag not set");
	a_timer_sets: assert property (ce && timer_e_req |=> irq_flags_group1[12])
		else $error("timer flag not set");
	a_change_sets: assert property (ce && pin_change_req |=> irq_flags_group1[3])
		else $error("change flag not set");
	a_spi_sets: assert property (ce && spi_b_error |=> irq_flags_group2[0])
		else $error("spi error flag not set");
	a_flag_sticky: assert property ($past(aresetn) && (|($past(all) & ~all))
		|-> $rose(s_axi_bvalid))
		else $error("flag cleared without a write");
	a_write_answer: assert property (both_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_bresp_hold: assert property (b_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule

bind irq_flag_bank irq_flag_bank_asserts chk (.*);

//--- sim/irq_flag_bank_bench.sv
// self-checking bench: register access, request mapping, interrupt
`timescale 1ns/10ps
`include "irq_flag_bank_map.vh"
module irq_flag_bank_bench;
	reg aclk = 1'b0;
	reg aresetn = 1'b0; // held low for five cycles
	reg ce = 1'b1; // enabled except while t_hold drops it
	reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	reg [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	reg [31:0] s_axi_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hF;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [15:0] irq_flags_group0, irq_flags_group1, irq_flags_group2;
	wire [47:0] flags = {irq_flags_group2, irq_flags_group1, irq_flags_group0};
	reg [47:0] cmd = 48'h0; // requested source levels
	wire [47:0] req;
	wire compare1_req, capture1_req, ext_pin0_req, uart_b_tx_req, uart_b_rx_req;
	wire ext_pin2_req, timer_e_req, timer_d_req, compare4_req, compare3_req;
	wire xfer_ch2_done, capture8_req, capture7_req, adc_b_done, ext_pin1_req;
	wire pin_change_req, i2c_a_master_req, i2c_a_slave_req, timer_f_req, xfer_ch4_done;
	wire compare8_req, compare7_req, compare6_req, compare5_req, capture6_req;
	wire capture5_req, capture4_req, capture3_req, xfer_ch3_done, can_a_event;
	wire can_a_rx_ready, spi_b_event, spi_b_error;
	// implemented positions per group, group0 only bits 2:0 here
	localparam [47:0] IMPL = {16'hDFFF, 16'hFFFB, 16'h0007};
	int n_fail = 0;
	int checks_done = 0;
	int slow = 0; // cycles the master lets pass before raising bready or rready
	//////////////////////////////
	// source bit to request port, the positions the flags must show
	assign {compare1_req, capture1_req, ext_pin0_req} = req[2:0];
	assign {uart_b_tx_req, uart_b_rx_req, ext_pin2_req, timer_e_req, timer_d_req,
		compare4_req, compare3_req, xfer_ch2_done} = req[31:24];
	assign {capture8_req, capture7_req, adc_b_done, ext_pin1_req, pin_change_req} = req[23:19];
	assign {i2c_a_master_req, i2c_a_slave_req} = req[17:16];
	assign {timer_f_req, xfer_ch4_done} = req[47:46];
	assign {compare8_req, compare7_req, compare6_req, compare5_req, capture6_req} = req[44:40];
	assign {capture5_req, capture4_req, capture3_req, xfer_ch3_done, can_a_event,
		can_a_rx_ready, spi_b_event, spi_b_error} = req[39:32];
	irq_flag_bank dut (.*);
	req_sources src (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .req(req));
	initial begin
		forever #12.5 aclk = ~aclk;
	end
	//////////////////////////////
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
		end
	endtask
	// ready is looked at mid-cycle, then released after the taking edge
	task wr(input [7:0] a, input [31:0] d, output [1:0] r);
		reg ga, gw, gb;
		int n;
		begin
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (slow == 0);
		gb = 1'b0;
		for (n = 0; n < 50 && !gb; n++) begin
			@(negedge aclk);
			ga = s_axi_awvalid & s_axi_awready;
			gw = s_axi_wvalid & s_axi_wready;
			gb = s_axi_bvalid & s_axi_bready;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ga) s_axi_awvalid <= 1'b0;
			if (gw) s_axi_wvalid <= 1'b0;
			if (gb) s_axi_bready <= 1'b0;
			else if (n >= slow) s_axi_bready <= 1'b1; // late ready stalls the response
		end
		chk("write answer", 32'h1, {31'h0, gb});
		end
	endtask
	task rd(input [7:0] a, output [31:0] d, output [1:0] r);
		reg ga, gr;
		int n;
		begin
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (slow == 0);
		gr = 1'b0;
		for (n = 0; n < 50 && !gr; n++) begin
			@(negedge aclk);
			ga = s_axi_arvalid & s_axi_arready;
			gr = s_axi_rvalid & s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ga) s_axi_arvalid <= 1'b0;
			if (gr) s_axi_rready <= 1'b0;
			else if (n >= slow) s_axi_rready <= 1'b1; // late ready stalls the data
		end
		chk("read answer", 32'h1, {31'h0, gr});
		end
	endtask
	// one-cycle request from source i
	task pulse(input int i);
		begin
		@(posedge aclk);
		cmd[i] <= 1'b1;
		@(posedge aclk);
		cmd[i] <= 1'b0;
		repeat (2) @(posedge aclk);
		end
	endtask
	//////////////////////////////
	task t_reset;
		reg [31:0] d;
		reg [1:0] r;
		int g;
		begin
		for (g = 0; g < 3; g++) begin
			rd(8'(g * 4), d, r);
			chk("flags at reset", 32'h0, d);
		end
		rd(`OFS_EVENT_MASK, d, r);
		chk("mask at reset", 32'h0, d);
		$display("t_reset done");
		end
	endtask
	// every position of every group: implemented ones set by their source, held, cleared
	task t_map;
		reg [31:0] d;
		reg [31:0] e;
		reg [1:0] r;
		int i;
		begin
		for (i = 0; i < 48; i++) begin
			e = IMPL[i] ? (32'h1 << (i % 16)) : 32'h0;
			pulse(i);
			rd(8'(i / 16 * 4), d, r);
			chk("flag read", e, d);
			@(negedge aclk);
			chk("flag view", e, {16'h0, flags[i / 16 * 16 +: 16]});
			wr(8'(i / 16 * 4), 32'h0, r);
			@(negedge aclk);
			chk("flag cleared", 32'h0, {16'h0, flags[i / 16 * 16 +: 16]});
		end
		$display("t_map done");
		end
	endtask
	task t_rw;
		reg [31:0] d;
		reg [1:0] r;
		int g;
		begin
		for (g = 0; g < 3; g++) begin
			slow = g;
			wr(8'(g * 4), 32'hFFFFFFFF, r);
			chk("write resp", `RESP_OKAY, {30'h0, r});
			rd(8'(g * 4), d, r);
			chk("ones read", {16'h0, IMPL[g * 16 +: 16]}, d);
			chk("read resp", `RESP_OKAY, {30'h0, r});
			wr(8'(g * 4), 32'h0, r);
			rd(8'(g * 4), d, r);
			chk("zeros read", 32'h0, d);
		end
		slow = 0;
		$display("t_rw done");
		end
	endtask
	// one-cycle request lands on the very edge of the clearing write
	task t_prio;
		reg [1:0] r;
		begin
		fork
			wr(`OFS_FLAGS_GROUP1, 32'h0, r);
			begin
				// cmd at the valid edge, seen by the bank two edges on with the write
				@(posedge aclk);
				cmd[28] <= 1'b1;
				@(posedge aclk);
				cmd[28] <= 1'b0;
			end
		join
		@(negedge aclk);
		chk("set wins", 32'h1000, {16'h0, irq_flags_group1});
		repeat (4) @(negedge aclk);
		chk("sticky", 32'h1000, {16'h0, irq_flags_group1});
		wr(`OFS_FLAGS_GROUP1, 32'h0, r);
		@(negedge aclk);
		chk("prio cleared", 32'h0, {16'h0, irq_flags_group1});
		$display("t_prio done");
		end
	endtask
	// clock enable low: a request is not taken until the enable returns
	task t_hold;
		reg [1:0] r;
		begin
		@(posedge aclk);
		ce <= 1'b0;
		cmd[0] <= 1'b1;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk("frozen flag", 32'h0, {16'h0, irq_flags_group0});
		@(posedge aclk);
		ce <= 1'b1;
		cmd[0] <= 1'b0;
		repeat (2) @(negedge aclk);
		chk("thawed flag", 32'h1, {16'h0, irq_flags_group0});
		wr(`OFS_FLAGS_GROUP0, 32'h0, r);
		$display("t_hold done");
		end
	endtask
	task t_irq;
		reg [31:0] d;
		reg [1:0] r;
		begin
		rd(`OFS_EVENT_STATUS, d, r);
		wr(`OFS_EVENT_MASK, 32'h2, r);
		pulse(21);
		@(negedge aclk);
		chk("irq raised", 32'h1, {31'h0, irq});
		rd(`OFS_EVENT_STATUS, d, r);
		chk("status", 32'h2, d);
		@(negedge aclk);
		chk("irq after read", 32'h0, {31'h0, irq});
		wr(`OFS_FLAGS_GROUP1, 32'h0, r);
		wr(`OFS_EVENT_MASK, 32'h0, r);
		pulse(1);
		@(negedge aclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		rd(`OFS_EVENT_STATUS, d, r);
		chk("masked status", 32'h1, d);
		wr(`OFS_FLAGS_GROUP0, 32'h0, r);
		$display("t_irq done");
		end
	endtask
	task t_unmap;
		reg [31:0] d;
		reg [1:0] r;
		begin
		wr(8'h20, 32'hFFFF, r);
		chk("unmapped bresp", `RESP_SLVERR, {30'h0, r});
		rd(8'h20, d, r);
		chk("unmapped rdata", 32'h0, d);
		chk("unmapped rresp", `RESP_SLVERR, {30'h0, r});
		$display("t_unmap done");
		end
	endtask
	task end_sim;
		begin
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
		end
	endtask
	//////////////////////////////
	// watchdog at 20000 cycles, far beyond the under one thousand cycles the tests take
	initial begin
		#500000;
		n_fail++;
		end_sim;
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_map;
		t_rw;
		t_prio;
		t_hold;
		t_irq;
		t_unmap;
		end_sim;
	end
endmodule
